// ### pause_frame_match_regs.sv
// flow control address, ethertype and pause time registers with frame match and header insertion
module pause_frame_match_regs #(
	parameter int IDX_W = pause_match_pkg::BYTE_IDX_W
) (
	input wire logic i_clk,
	input wire logic i_reset_n,
	input wire logic [8:0] i_reg_addr,
	input wire logic i_reg_wr,
	input wire logic i_reg_rd,
	input wire logic i_reg_wide,
	input wire logic [63:0] i_reg_wdata,
	output logic [63:0] o_reg_rdata,
	output logic o_reg_ack,
	input wire pause_match_pkg::rx_beat_t i_rx,
	output logic o_rx_pause_hit,
	output logic o_rx_vlan_hit,
	input wire logic [47:0] i_station_addr,
	input wire logic i_tx_pause_req,
	input wire logic i_tx_vlan_req,
	input wire logic [15:0] i_vlan_tci,
	input wire logic i_tx_ready,
	output pause_match_pkg::tx_beat_t o_tx,
	output logic o_tx_busy,
	output logic [21:0] o_pause_byte_times
);

	// ==========================================
	// elaboration checks
	if (IDX_W != pause_match_pkg::BYTE_IDX_W) begin : g_bad_idx
		$error("byte index width must match the frame layout");
	end

	// ==========================================
	// reset release, asynchronous assert, clocked release
	logic rst_meta, rst_n;

	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			rst_meta <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_n <= rst_meta;
		end
	end

	// ==========================================
	// host register file
	logic [31:0] fc_addr_low, next_fc_addr_low;
	logic [15:0] fc_addr_high, next_fc_addr_high;
	logic [15:0] fc_type, next_fc_type;
	logic [15:0] vlan_type, next_vlan_type;
	logic [15:0] pause_slot_count, next_pause_slot_count;
	logic [63:0] rdata, next_rdata;
	logic ack, next_ack;
	logic [47:0] fc_addr;

	// address decode shared by reads and writes
	function automatic logic hit(input logic [8:0] a, input logic [8:0] ofs);
		return a == ofs;
	endfunction

	assign fc_addr = {fc_addr_high, fc_addr_low};

	// writes ignore the reserved upper halves, reads return them as zero
	always_comb begin
		next_fc_addr_low = fc_addr_low;
		next_fc_addr_high = fc_addr_high;
		next_fc_type = fc_type;
		next_vlan_type = vlan_type;
		next_pause_slot_count = pause_slot_count;
		next_ack = i_reg_rd | i_reg_wr;
		next_rdata = rdata;
		if (i_reg_wr) begin
			if (hit(i_reg_addr, pause_match_pkg::FC_ADDR_LOW_OFS)) begin
				next_fc_addr_low = i_reg_wdata[31:0];
				if (i_reg_wide) begin
					next_fc_addr_high = i_reg_wdata[47:32];
				end
			end
			if (hit(i_reg_addr, pause_match_pkg::FC_ADDR_HIGH_OFS)) begin
				next_fc_addr_high = i_reg_wdata[15:0];
			end
			if (hit(i_reg_addr, pause_match_pkg::FC_ETHERTYPE_OFS)) begin
				next_fc_type = i_reg_wdata[15:0];
			end
			if (hit(i_reg_addr, pause_match_pkg::VLAN_ETHERTYPE_OFS)) begin
				next_vlan_type = i_reg_wdata[15:0];
			end
			if (hit(i_reg_addr, pause_match_pkg::PAUSE_TIME_OFS)) begin
				next_pause_slot_count = i_reg_wdata[15:0];
			end
		end
		if (i_reg_rd) begin
			// unmapped addresses read as zero
			next_rdata = 64'h0000_0000_0000_0000;
			if (hit(i_reg_addr, pause_match_pkg::FC_ADDR_LOW_OFS)) begin
				next_rdata[31:0] = fc_addr_low;
				if (i_reg_wide) begin
					next_rdata[63:32] = {pause_match_pkg::RESERVED_ZERO, fc_addr_high};
				end
			end
			if (hit(i_reg_addr, pause_match_pkg::FC_ADDR_HIGH_OFS)) begin
				next_rdata[31:0] = {pause_match_pkg::RESERVED_ZERO, fc_addr_high};
			end
			if (hit(i_reg_addr, pause_match_pkg::FC_ETHERTYPE_OFS)) begin
				next_rdata[31:0] = {pause_match_pkg::RESERVED_ZERO, fc_type};
			end
			if (hit(i_reg_addr, pause_match_pkg::VLAN_ETHERTYPE_OFS)) begin
				next_rdata[31:0] = {pause_match_pkg::RESERVED_ZERO, vlan_type};
			end
			if (hit(i_reg_addr, pause_match_pkg::PAUSE_TIME_OFS)) begin
				next_rdata[31:0] = {pause_match_pkg::RESERVED_ZERO, pause_slot_count};
			end
		end
	end

	// register file flops
	always_ff @(posedge i_clk or negedge rst_n) begin
		if (!rst_n) begin
			fc_addr_low <= pause_match_pkg::FC_ADDR_LOW_RST;
			fc_addr_high <= pause_match_pkg::FIELD_RST;
			fc_type <= pause_match_pkg::FIELD_RST;
			vlan_type <= pause_match_pkg::FIELD_RST;
			pause_slot_count <= pause_match_pkg::FIELD_RST;
			rdata <= 64'h0000_0000_0000_0000;
			ack <= 1'b0;
		end else begin
			fc_addr_low <= next_fc_addr_low;
			fc_addr_high <= next_fc_addr_high;
			fc_type <= next_fc_type;
			vlan_type <= next_vlan_type;
			pause_slot_count <= next_pause_slot_count;
			rdata <= next_rdata;
			ack <= next_ack;
		end
	end

	assign o_reg_rdata = rdata;
	assign o_reg_ack = ack;

	// ==========================================
	// receive match
	rx_frame_matcher u_rx_match (
		.i_clk(i_clk),
		.i_rst_n(rst_n),
		.i_rx(i_rx),
		.i_fc_addr(fc_addr),
		.i_fc_type(fc_type),
		.i_vlan_type(vlan_type),
		.o_pause_hit(o_rx_pause_hit),
		.o_vlan_hit(o_rx_vlan_hit)
	);

	// ==========================================
	// transmit header generator
	pause_match_pkg::tx_state_t state, next_state;
	logic [4:0] idx, next_idx;
	logic [47:0] sa_hold, next_sa_hold;
	logic [15:0] time_hold, next_time_hold;
	logic [15:0] tci_hold, next_tci_hold;
	pause_match_pkg::tx_beat_t beat, next_beat;
	logic [21:0] byte_times, next_byte_times;
	logic advance;

	// pause frame byte: addresses low byte first, 16-bit fields high byte first
	function automatic logic [7:0] pause_byte(input logic [4:0] i, input logic [47:0] da,
			input logic [47:0] sa, input logic [15:0] typ, input logic [15:0] tim);
		logic [47:0] s;
		s = 48'h0000_0000_0000;
		if (i <= pause_match_pkg::DA_LAST_IDX) begin
			s = da >> {i, 3'b000};
		end else if (i < pause_match_pkg::TYPE_HI_IDX) begin
			s = sa >> {i - pause_match_pkg::SA_FIRST_IDX, 3'b000};
		end else if (i == pause_match_pkg::TYPE_HI_IDX) begin
			s[7:0] = typ[15:8];
		end else if (i == pause_match_pkg::TYPE_LO_IDX) begin
			s[7:0] = typ[7:0];
		end else if (i == pause_match_pkg::OPCODE_HI_IDX) begin
			s[7:0] = pause_match_pkg::PAUSE_OPCODE[15:8];
		end else if (i == pause_match_pkg::OPCODE_LO_IDX) begin
			s[7:0] = pause_match_pkg::PAUSE_OPCODE[7:0];
		end else if (i == pause_match_pkg::TIME_HI_IDX) begin
			s[7:0] = tim[15:8];
		end else begin
			s[7:0] = tim[7:0];
		end
		return s[7:0];
	endfunction

	// vlan tag byte: tag type then control word, both high byte first
	function automatic logic [7:0] vlan_byte(input logic [4:0] i, input logic [15:0] typ,
			input logic [15:0] tci);
		logic [31:0] tag;
		logic [31:0] s;
		tag = {typ, tci};
		s = tag << {i, 3'b000};
		return s[31:24];
	endfunction

	assign advance = beat.valid & i_tx_ready;

	// a request starts a header from idle; after that the generator only moves when the consumer takes the byte in front
	always_comb begin
		next_state = state;
		next_idx = idx;
		next_sa_hold = sa_hold;
		next_time_hold = time_hold;
		next_tci_hold = tci_hold;
		next_beat = beat;
		next_byte_times = byte_times;
		case (state)
			pause_match_pkg::TX_IDLE: begin
				next_beat.valid = 1'b0;
				if (i_tx_pause_req) begin
					next_state = pause_match_pkg::TX_PAUSE;
					next_idx = 5'h00;
					next_sa_hold = i_station_addr;
					next_time_hold = pause_slot_count;
					next_byte_times = {pause_slot_count, {pause_match_pkg::SLOT_SHIFT{1'b0}}};
					next_beat = '{valid: 1'b1, last: 1'b0,
						data: pause_byte(5'h00, fc_addr, i_station_addr, fc_type,
							pause_slot_count)};
				end else if (i_tx_vlan_req) begin
					next_state = pause_match_pkg::TX_VLAN;
					next_idx = 5'h00;
					next_tci_hold = i_vlan_tci;
					next_beat = '{valid: 1'b1, last: 1'b0,
						data: vlan_byte(5'h00, vlan_type, i_vlan_tci)};
				end
			end
			pause_match_pkg::TX_PAUSE: begin
				if (advance) begin
					if (beat.last) begin
						next_state = pause_match_pkg::TX_IDLE;
						next_beat = '{valid: 1'b0, last: 1'b0, data: 8'h00};
					end else begin
						next_idx = idx + pause_match_pkg::IDX_ONE;
						next_beat = '{valid: 1'b1,
							last: next_idx == pause_match_pkg::PAUSE_LAST_IDX,
							data: pause_byte(next_idx, fc_addr, sa_hold, fc_type,
								time_hold)};
					end
				end
			end
			pause_match_pkg::TX_VLAN: begin
				if (advance) begin
					if (beat.last) begin
						next_state = pause_match_pkg::TX_IDLE;
						next_beat = '{valid: 1'b0, last: 1'b0, data: 8'h00};
					end else begin
						next_idx = idx + pause_match_pkg::IDX_ONE;
						next_beat = '{valid: 1'b1,
							last: next_idx == pause_match_pkg::VLAN_LAST_IDX,
							data: vlan_byte(next_idx, vlan_type, tci_hold)};
					end
				end
			end
			default: begin
				next_state = pause_match_pkg::TX_IDLE;
				next_beat = '{valid: 1'b0, last: 1'b0, data: 8'h00};
			end
		endcase
	end

	// generator flops
	always_ff @(posedge i_clk or negedge rst_n) begin
		if (!rst_n) begin
			state <= pause_match_pkg::TX_IDLE;
			idx <= 5'h00;
			sa_hold <= 48'h0000_0000_0000;
			time_hold <= pause_match_pkg::FIELD_RST;
			tci_hold <= pause_match_pkg::FIELD_RST;
			beat <= '{valid: 1'b0, last: 1'b0, data: 8'h00};
			byte_times <= 22'h00_0000;
		end else begin
			state <= next_state;
			idx <= next_idx;
			sa_hold <= next_sa_hold;
			time_hold <= next_time_hold;
			tci_hold <= next_tci_hold;
			beat <= next_beat;
			byte_times <= next_byte_times;
		end
	end

	assign o_tx = beat;
	assign o_tx_busy = beat.valid;
	assign o_pause_byte_times = byte_times;

	// ==========================================
	// checks
	a_read_ack: assert property (@(posedge i_clk) disable iff (!rst_n)
		(i_reg_rd || i_reg_wr) |=> o_reg_ack)
		else $error("access not acknowledged next cycle");

	a_low_write: assert property (@(posedge i_clk) disable iff (!rst_n)
		(i_reg_wr && i_reg_addr == pause_match_pkg::FC_ADDR_LOW_OFS)
		|=> fc_addr_low == $past(i_reg_wdata[31:0]))
		else $error("low address word not stored whole");

	a_wide_pair: assert property (@(posedge i_clk) disable iff (!rst_n)
		(i_reg_wr && i_reg_wide && i_reg_addr == pause_match_pkg::FC_ADDR_LOW_OFS)
		|=> fc_addr_high == $past(i_reg_wdata[47:32]))
		else $error("wide write missed the high half");

	a_high_reserved: assert property (@(posedge i_clk) disable iff (!rst_n)
		(i_reg_rd && i_reg_addr == pause_match_pkg::FC_ADDR_HIGH_OFS)
		|=> o_reg_rdata[63:16] == 48'h0000_0000_0000)
		else $error("reserved high address bits not zero");

	a_da_first: assert property (@(posedge i_clk) disable iff (!rst_n)
		(state == pause_match_pkg::TX_IDLE && i_tx_pause_req && !i_reg_wr)
		|=> o_tx.valid && o_tx.data == fc_addr_low[7:0])
		else $error("pause frame did not open with lowest address byte");

	a_type_order: assert property (@(posedge i_clk) disable iff (!rst_n)
		(state == pause_match_pkg::TX_PAUSE && idx == pause_match_pkg::TYPE_HI_IDX)
		|-> o_tx.data == fc_type[15:8])
		else $error("flow ethertype high byte not first");

	a_time_copy: assert property (@(posedge i_clk) disable iff (!rst_n)
		(state == pause_match_pkg::TX_IDLE && i_tx_pause_req && !i_reg_wr)
		|=> time_hold == pause_slot_count
		&& o_pause_byte_times == {pause_slot_count, {pause_match_pkg::SLOT_SHIFT{1'b0}}})
		else $error("pause time not captured or scaled");

	a_vlan_order: assert property (@(posedge i_clk) disable iff (!rst_n)
		(state == pause_match_pkg::TX_VLAN && idx == 5'h00) |-> o_tx.data == vlan_type[15:8])
		else $error("vlan ethertype high byte not first");

endmodule

// ### pause_match_pkg.sv
// shared constants, field layouts and carrier types for the pause and vlan match block
package pause_match_pkg;

	// ==========================================
	// register map, byte addresses on the host port
	localparam int REG_ADDR_W = 9;
	localparam logic [8:0] FC_ADDR_LOW_OFS = 9'h028;
	localparam logic [8:0] FC_ADDR_HIGH_OFS = 9'h02C;
	localparam logic [8:0] FC_ETHERTYPE_OFS = 9'h030;
	localparam logic [8:0] VLAN_ETHERTYPE_OFS = 9'h038;
	localparam logic [8:0] PAUSE_TIME_OFS = 9'h170;

	// ==========================================
	// field layouts and reset values
	localparam int FIELD_W = 16;
	localparam int LOW_W = 32;
	localparam int MAC_ADDR_W = 48;
	localparam logic [31:0] FC_ADDR_LOW_RST = 32'h0000_0000;
	localparam logic [15:0] FIELD_RST = 16'h0000;
	localparam logic [15:0] RESERVED_ZERO = 16'h0000;
	localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

	// ==========================================
	// frame layout, byte positions counted from the first byte on the wire
	localparam int BYTE_IDX_W = 5;
	localparam logic [4:0] DA_LAST_IDX = 5'h05;
	localparam logic [4:0] SA_FIRST_IDX = 5'h06;
	localparam logic [4:0] TYPE_HI_IDX = 5'h0C;
	localparam logic [4:0] TYPE_LO_IDX = 5'h0D;
	localparam logic [4:0] OPCODE_HI_IDX = 5'h0E;
	localparam logic [4:0] OPCODE_LO_IDX = 5'h0F;
	localparam logic [4:0] TIME_HI_IDX = 5'h10;
	localparam logic [4:0] PAUSE_LAST_IDX = 5'h11;
	localparam logic [4:0] VLAN_LAST_IDX = 5'h03;
	localparam logic [4:0] IDX_SATURATE = 5'h1F;
	localparam logic [4:0] IDX_ONE = 5'h01;
	localparam logic [15:0] PAUSE_OPCODE = 16'h0001;

	// ==========================================
	// one pause slot is the time of 64 bytes
	localparam int PAUSE_SLOT_BYTES = 64;
	localparam int SLOT_SHIFT = $clog2(PAUSE_SLOT_BYTES);
	localparam int BYTE_TIMES_W = FIELD_W + SLOT_SHIFT;

	// ==========================================
	// carriers
	typedef struct packed {
		logic valid;
		logic sof;
		logic [7:0] data;
	} rx_beat_t;

	typedef struct packed {
		logic valid;
		logic last;
		logic [7:0] data;
	} tx_beat_t;

	typedef enum logic [2:0] {
		TX_IDLE = 3'b001,
		TX_PAUSE = 3'b010,
		TX_VLAN = 3'b100
	} tx_state_t;

endpackage

// ### rx_frame_matcher.sv
// receive side comparison of destination address and type field
module rx_frame_matcher (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire pause_match_pkg::rx_beat_t i_rx,
	input wire logic [47:0] i_fc_addr,
	input wire logic [15:0] i_fc_type,
	input wire logic [15:0] i_vlan_type,
	output logic o_pause_hit,
	output logic o_vlan_hit
);

	// ==========================================
	// position and match tracking
	logic [4:0] idx, next_idx, cur;
	logic da_ok, next_da_ok;
	logic fc_hi_ok, next_fc_hi_ok;
	logic vlan_hi_ok, next_vlan_hi_ok;
	logic pause_hit, next_pause_hit;
	logic vlan_hit, next_vlan_hit;
	logic da_byte_ok;

	// address bytes are laid on the wire lowest byte first
	function automatic logic [7:0] addr_byte(input logic [47:0] a, input logic [4:0] i);
		logic [47:0] s;
		s = a >> {i, 3'b000};
		return s[7:0];
	endfunction

	// compute next match state for each received byte
	always_comb begin
		cur = i_rx.sof ? 5'h00 : idx;
		next_idx = idx;
		next_da_ok = da_ok;
		next_fc_hi_ok = fc_hi_ok;
		next_vlan_hi_ok = vlan_hi_ok;
		next_pause_hit = 1'b0;
		next_vlan_hit = 1'b0;
		da_byte_ok = i_rx.data == addr_byte(i_fc_addr, cur);
		if (i_rx.valid) begin
			next_idx = (cur == pause_match_pkg::IDX_SATURATE) ? cur : cur + pause_match_pkg::IDX_ONE;
			if (cur == 5'h00) begin
				next_da_ok = da_byte_ok;
			end else if (cur <= pause_match_pkg::DA_LAST_IDX) begin
				next_da_ok = da_ok & da_byte_ok;
			end
			// type field arrives high byte first
			if (cur == pause_match_pkg::TYPE_HI_IDX) begin
				next_fc_hi_ok = i_rx.data == i_fc_type[15:8];
				next_vlan_hi_ok = i_rx.data == i_vlan_type[15:8];
			end
			if (cur == pause_match_pkg::TYPE_LO_IDX) begin
				// both address and type must agree before pausing
				next_pause_hit = da_ok & fc_hi_ok & (i_rx.data == i_fc_type[7:0]);
				next_vlan_hit = vlan_hi_ok & (i_rx.data == i_vlan_type[7:0]);
			end
		end
	end

	// register match state
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			idx <= 5'h00;
			da_ok <= 1'b0;
			fc_hi_ok <= 1'b0;
			vlan_hi_ok <= 1'b0;
			pause_hit <= 1'b0;
			vlan_hit <= 1'b0;
		end else begin
			idx <= next_idx;
			da_ok <= next_da_ok;
			fc_hi_ok <= next_fc_hi_ok;
			vlan_hi_ok <= next_vlan_hi_ok;
			pause_hit <= next_pause_hit;
			vlan_hit <= next_vlan_hit;
		end
	end

	assign o_pause_hit = pause_hit;
	assign o_vlan_hit = vlan_hit;

	a_pause_needs_da: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		o_pause_hit |-> $past(da_ok) && $past(fc_hi_ok))
		else $error("pause hit without address and type match");

endmodule

// ### link_partner_model.sv
// far end station model: takes transmitted bytes and sends received headers
module link_partner_model (
	input wire logic i_clk,
	input wire logic i_stall,
	input wire pause_match_pkg::tx_beat_t i_tx,
	output logic o_ready,
	output pause_match_pkg::rx_beat_t o_rx
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] got[$];
	int last_at;
	logic phase;
	initial begin
		o_rx = '0;
		o_ready = 1'b1;
		phase = 1'b0;
		last_at = -1;
	end
	// ready drops every other cycle when stalling, so bytes must hold
	always @(negedge i_clk) begin
		phase <= ~phase;
		o_ready <= ~i_stall | phase;
	end
	// capture on the edge at which the block sees the handshake
	always @(posedge i_clk) begin
		if (i_tx.valid && o_ready) begin
			if (i_tx.last) begin
				last_at = got.size();
			end
			got.push_back(i_tx.data);
		end
	end
	task automatic clear();
		got.delete();
		last_at = -1;
	endtask
	// destination low byte first, type high byte first
	task automatic send_frame(input logic [47:0] da, input logic [15:0] typ);
		logic [7:0] b;
		for (int i = 0; i < 14; i++) begin
			@(negedge i_clk);
			b = (i < 6) ? da[8*i +: 8] : (i == 12) ? typ[15:8] : (i == 13) ? typ[7:0] : 8'hA5;
			o_rx <= '{valid: 1'b1, sof: (i == 0), data: b};
		end
		@(negedge i_clk);
		// idle line shows the inverse of the last byte, never a stale copy
		o_rx <= '{valid: 1'b0, sof: 1'b0, data: ~b};
	endtask
endmodule

// ### pause_frame_match_regs_tb.sv
// self-checking bench for the pause and vlan match block
module pause_frame_match_regs_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic i_clk;
	logic i_reset_n;
	logic [8:0] i_reg_addr;
	logic i_reg_wr;
	logic i_reg_rd;
	logic i_reg_wide;
	logic [63:0] i_reg_wdata;
	logic [63:0] o_reg_rdata;
	logic o_reg_ack;
	pause_match_pkg::rx_beat_t i_rx;
	logic o_rx_pause_hit;
	logic o_rx_vlan_hit;
	logic [47:0] i_station_addr;
	logic i_tx_pause_req;
	logic i_tx_vlan_req;
	logic [15:0] i_vlan_tci;
	logic i_tx_ready;
	pause_match_pkg::tx_beat_t o_tx;
	logic o_tx_busy;
	logic [21:0] o_pause_byte_times;
	logic stall;
	int err_total;
	int comparisons;
	localparam logic [47:0] FC_ADDR = 48'h0100_00C2_8001;
	localparam logic [47:0] SA = 48'h0A0B_0C0D_0E0F;
	localparam logic [8:0] OFS[5] = '{9'h028, 9'h02C, 9'h030, 9'h038, 9'h170};

	pause_frame_match_regs i_pause_frame_match_regs (.i_clk(i_clk), .i_reset_n(i_reset_n),
		.i_reg_addr(i_reg_addr), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
		.i_reg_wide(i_reg_wide), .i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata),
		.o_reg_ack(o_reg_ack), .i_rx(i_rx), .o_rx_pause_hit(o_rx_pause_hit),
		.o_rx_vlan_hit(o_rx_vlan_hit), .i_station_addr(i_station_addr),
		.i_tx_pause_req(i_tx_pause_req), .i_tx_vlan_req(i_tx_vlan_req),
		.i_vlan_tci(i_vlan_tci), .i_tx_ready(i_tx_ready), .o_tx(o_tx),
		.o_tx_busy(o_tx_busy), .o_pause_byte_times(o_pause_byte_times));
	link_partner_model i_link_partner_model (.i_clk(i_clk), .i_stall(stall), .i_tx(o_tx),
		.o_ready(i_tx_ready), .o_rx(i_rx));

	// ==========================================
	// clock, verdict and compare
	initial begin
		i_clk = 1'b0;
		forever #50 i_clk = ~i_clk;
	end
	task automatic print_verdict();
		if (err_total == 0 && comparisons > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
		comparisons++;
		if (got !== exp) begin
			err_total++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask

	// ==========================================
	// register access: strobe one cycle, ack one cycle later
	task automatic reg_op(input logic wr, input logic wide, input logic [8:0] a,
			input logic [63:0] d, output logic [63:0] q);
		int n;
		@(negedge i_clk);
		i_reg_addr = a;
		i_reg_wr = wr;
		i_reg_rd = ~wr;
		i_reg_wide = wide;
		i_reg_wdata = d;
		@(negedge i_clk);
		i_reg_wr = 1'b0;
		i_reg_rd = 1'b0;
		n = 0;
		while (o_reg_ack !== 1'b1 && n < 4) begin
			@(negedge i_clk);
			n++;
		end
		if (n == 4) begin
			err_total++;
			print_verdict();
		end
		q = o_reg_rdata;
	endtask
	task automatic wr(input logic [8:0] a, input logic wide, input logic [63:0] d);
		logic [63:0] q;
		reg_op(1'b1, wide, a, d, q);
	endtask
	task automatic rd_chk(input logic [8:0] a, input logic wide, input logic [63:0] exp);
		logic [63:0] q;
		reg_op(1'b0, wide, a, 64'h0, q);
		chk("register read", exp, q);
	endtask

	// ==========================================
	// scenarios
	task automatic t_regs();
		for (int i = 0; i < 5; i++) begin
			rd_chk(OFS[i], 1'b0, 64'h0);
			wr(OFS[i], 1'b0, 64'hFFFF_FFFF_FFFF_FFFF);
		end
		rd_chk(9'h028, 1'b0, 64'h0000_0000_FFFF_FFFF);
		for (int i = 1; i < 5; i++) begin
			rd_chk(OFS[i], 1'b0, 64'h0000_0000_0000_FFFF);
		end
		wr(9'h034, 1'b0, 64'h0000_0000_1234_5678);
		rd_chk(9'h034, 1'b0, 64'h0);
		wr(9'h028, 1'b1, 64'hFFFF_A1B2_C3D4_E5F6);
		rd_chk(9'h028, 1'b1, 64'h0000_A1B2_C3D4_E5F6);
		rd_chk(9'h02C, 1'b0, 64'h0000_0000_0000_A1B2);
		// a wide read away from the address pair must leave the upper word zero
		rd_chk(9'h030, 1'b1, 64'h0000_0000_0000_FFFF);
	endtask
	// standard multicast address and types, as software loads them
	task automatic t_program();
		wr(9'h028, 1'b0, 64'h0000_0000_00C2_8001);
		wr(9'h02C, 1'b0, 64'h0000_0000_0000_0100);
		wr(9'h030, 1'b0, 64'h0000_0000_0000_8808);
		wr(9'h038, 1'b0, 64'h0000_0000_0000_8100);
	endtask
	task automatic t_rx(input logic [47:0] da, input logic [15:0] typ, input logic ep,
			input logic ev);
		i_link_partner_model.send_frame(da, typ);
		chk("pause hit", 64'(ep), 64'(o_rx_pause_hit));
		chk("vlan hit", 64'(ev), 64'(o_rx_vlan_hit));
		@(negedge i_clk);
		chk("pause hit pulse", 64'h0, 64'(o_rx_pause_hit));
		chk("vlan hit pulse", 64'h0, 64'(o_rx_vlan_hit));
	endtask
	task automatic t_tx(input logic vlan, input logic stl, input logic [15:0] v);
		logic [143:0] hdr;
		logic [7:0] b;
		int n;
		int len;
		stall = stl;
		i_link_partner_model.clear();
		if (vlan) begin
			hdr = 144'({v[7:0], v[15:8], 16'h0081});
			len = 4;
		end else begin
			wr(9'h170, 1'b0, 64'(v));
			hdr = {v[7:0], v[15:8], 16'h0100, 16'h0888, SA, FC_ADDR};
			len = 18;
		end
		@(negedge i_clk);
		i_vlan_tci = v;
		i_tx_vlan_req = vlan;
		i_tx_pause_req = ~vlan;
		@(negedge i_clk);
		i_tx_vlan_req = 1'b0;
		i_tx_pause_req = 1'b0;
		if (!vlan) begin
			chk("byte times", 64'(v) * 64, 64'(o_pause_byte_times));
		end
		n = 0;
		while (o_tx_busy !== 1'b0 && n < 100) begin
			@(negedge i_clk);
			n++;
		end
		if (n == 100) begin
			err_total++;
			print_verdict();
		end
		chk("tx length", 64'(len), 64'(i_link_partner_model.got.size()));
		chk("last index", 64'(len - 1), 64'(i_link_partner_model.last_at));
		for (int k = 0; k < len && k < i_link_partner_model.got.size(); k++) begin
			b = i_link_partner_model.got[k];
			chk("tx byte", 64'(hdr[8*k +: 8]), 64'(b));
		end
	endtask

	// ==========================================
	// main sequence
	initial begin
		err_total = 0;
		comparisons = 0;
		stall = 1'b0;
		i_reset_n = 1'b0;
		i_reg_addr = 9'h000;
		i_reg_wr = 1'b0;
		i_reg_rd = 1'b0;
		i_reg_wide = 1'b0;
		i_reg_wdata = 64'h0;
		i_station_addr = SA;
		i_tx_pause_req = 1'b0;
		i_tx_vlan_req = 1'b0;
		i_vlan_tci = 16'h0000;
		repeat (4) @(negedge i_clk);
		i_reset_n = 1'b1;
		repeat (3) @(posedge i_clk);
		t_regs();
		t_program();
		t_rx(FC_ADDR, 16'h8808, 1'b1, 1'b0);
		t_rx(FC_ADDR ^ 48'h0000_0100_0000, 16'h8808, 1'b0, 1'b0);
		t_rx(FC_ADDR, 16'h8100, 1'b0, 1'b1);
		t_tx(1'b0, 1'b1, 16'h1234);
		t_tx(1'b0, 1'b0, 16'h0000);
		t_tx(1'b1, 1'b1, 16'h6ABC);
		print_verdict();
	end
endmodule
